/* hdl/lkd_pkg.sv */
// Package: register map, config fields and window thresholds of the lock detector
package lkd_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [9:0] LKD_CFG_ADDR  = 10'h018;
  localparam logic [7:0] LKD_CFG_RESET = 8'h06;
  localparam int         LKD_ADDR_W    = 10;

  // Field positions of lock_detect_and_ref_input_cfg
  localparam int LKD_DC_OFFSET_BIT = 7;
  localparam int LKD_CNT_SEL_HI    = 6;
  localparam int LKD_CNT_SEL_LO    = 5;
  localparam int LKD_WIN_SEL_BIT   = 4;
  localparam int LKD_DISABLE_BIT   = 3;

  // ****************************************************************
  // Lock counts per count-select code
  // ****************************************************************
  localparam logic [7:0] LKD_CNT_SEL0 = 8'h05;
  localparam logic [7:0] LKD_CNT_SEL1 = 8'h10;
  localparam logic [7:0] LKD_CNT_SEL2 = 8'h40;
  localparam logic [7:0] LKD_CNT_SEL3 = 8'hFF;

  // ****************************************************************
  // Windows, in picoseconds, and the step of the edge difference input
  // ****************************************************************
  localparam int LKD_STEP_PS       = 100;
  localparam int LKD_LOCK_HI_PS    = 3500;
  localparam int LKD_UNLOCK_HI_PS  = 7000;
  localparam int LKD_LOCK_LO_PS    = 1500;
  localparam int LKD_UNLOCK_LO_PS  = 3000;
  localparam int LKD_LOCK_HI_STEPS   = LKD_LOCK_HI_PS / LKD_STEP_PS;
  localparam int LKD_UNLOCK_HI_STEPS = LKD_UNLOCK_HI_PS / LKD_STEP_PS;
  localparam int LKD_LOCK_LO_STEPS   = LKD_LOCK_LO_PS / LKD_STEP_PS;
  localparam int LKD_UNLOCK_LO_STEPS = LKD_UNLOCK_LO_PS / LKD_STEP_PS;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       dc_offset_en;
    logic [1:0] cnt_sel;
    logic       win_low;
    logic       lock_dis;
    logic [2:0] other;
  } lkd_cfg_t;

  typedef struct packed {
    logic                  wr;
    logic [LKD_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
  } lkd_reg_req_t;

endpackage : lkd_pkg

/* hdl/lkd_run_counter.sv */
// Saturating run counter that flags when a target count is reached
`timescale 1ns/10ps
module lkd_run_counter #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic             clr_i,
  input  wire logic             inc_i,
  input  wire logic [CNT_W-1:0] target_i,
  // Status
  output logic      [CNT_W-1:0] count_o,
  output logic                  reached_o
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  generate
    if (CNT_W < 1) begin : g_bad_width
      $error("lkd_run_counter: CNT_W must be at least 1");
    end
  endgenerate

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clr_i) begin
      nxt_cnt = '0;
    end else if (inc_i && (cnt_ff != target_i)) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign count_o   = cnt_ff;
  assign reached_o = (nxt_cnt == target_i) && inc_i && !clr_i;

endmodule : lkd_run_counter

/* hdl/lkd_digital_lock_detect.sv */
// Digital lock detector with its configuration register
`timescale 1ns/10ps

// Contract
// - Count consecutive in-window cycles; raise flag at programmed count; restart outside window.
// - Count select 00/01/10/11 requires 5/16/64/255 cycles; 00 is the reset value.
// - Edge difference below the selected lock window sets the lock flag.
// - Flag stays set until edge difference exceeds the loss-of-lock threshold or config bit 3 disables lock detection.
// - Config bit 7 enables the reference dc offset; reset value is disabled.
module lkd_digital_lock_detect #(
  parameter int DIFF_W = 8
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Register port
  input  wire logic              reg_wr_i,
  input  wire logic [9:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  // Phase/frequency comparator edge timing
  input  wire logic              cmp_strobe_i,
  input  wire logic [DIFF_W-1:0] cmp_diff_i,
  // Status and controls
  output logic                   digital_lock_flag_o,
  output logic [7:0]             lock_count_o,
  output logic                   ref_dc_offset_en_o
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  generate
    if ((DIFF_W < 1) || (DIFF_W > 16) ||
        ((1 << DIFF_W) <= lkd_pkg::LKD_UNLOCK_HI_STEPS)) begin : g_bad_width
      $error("lkd_digital_lock_detect: DIFF_W cannot hold the window thresholds");
    end
  endgenerate

  localparam logic [DIFF_W-1:0] LOCK_HI   = DIFF_W'(lkd_pkg::LKD_LOCK_HI_STEPS);
  localparam logic [DIFF_W-1:0] UNLOCK_HI = DIFF_W'(lkd_pkg::LKD_UNLOCK_HI_STEPS);
  localparam logic [DIFF_W-1:0] LOCK_LO   = DIFF_W'(lkd_pkg::LKD_LOCK_LO_STEPS);
  localparam logic [DIFF_W-1:0] UNLOCK_LO = DIFF_W'(lkd_pkg::LKD_UNLOCK_LO_STEPS);

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  lkd_pkg::lkd_reg_req_t req;
  lkd_pkg::lkd_cfg_t     cfg_ff;
  lkd_pkg::lkd_cfg_t     nxt_cfg;
  logic [7:0]            rdata_ff;
  logic [7:0]            nxt_rdata;

  assign req = '{wr: reg_wr_i, addr: reg_addr_i, wdata: reg_wdata_i};

  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_rdata = 8'h00;
    if (req.addr == lkd_pkg::LKD_CFG_ADDR) begin
      nxt_rdata = cfg_ff;
      if (req.wr) begin
        nxt_cfg = lkd_pkg::lkd_cfg_t'(req.wdata);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff   <= lkd_pkg::lkd_cfg_t'(lkd_pkg::LKD_CFG_RESET);
      rdata_ff <= 8'h00;
    end else begin
      cfg_ff   <= nxt_cfg;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o        = rdata_ff;
  assign ref_dc_offset_en_o = cfg_ff.dc_offset_en;

  // ****************************************************************
  // Window compare
  // ****************************************************************
  logic [7:0]        target;
  logic [DIFF_W-1:0] lock_win;
  logic [DIFF_W-1:0] unlock_thr;
  logic              in_win;
  logic              beyond_thr;

  always_comb begin
    unique case (cfg_ff.cnt_sel)
      2'b00: target = lkd_pkg::LKD_CNT_SEL0;
      2'b01: target = lkd_pkg::LKD_CNT_SEL1;
      2'b10: target = lkd_pkg::LKD_CNT_SEL2;
      2'b11: target = lkd_pkg::LKD_CNT_SEL3;
    endcase
  end

  // Low range uses the tighter pair of windows
  assign lock_win   = cfg_ff.win_low ? LOCK_LO : LOCK_HI;
  assign unlock_thr = cfg_ff.win_low ? UNLOCK_LO : UNLOCK_HI;
  assign in_win     = cmp_diff_i < lock_win;
  assign beyond_thr = cmp_diff_i > unlock_thr;

  // ****************************************************************
  // Consecutive cycle counter and lock flag
  // ****************************************************************
  logic cnt_clr;
  logic cnt_inc;
  logic reached;
  logic lock_ff;
  logic nxt_lock;

  // An out-of-window edge restarts the run even while the flag holds
  assign cnt_clr = cfg_ff.lock_dis || (cmp_strobe_i && !in_win);
  assign cnt_inc = cmp_strobe_i && in_win;

  lkd_run_counter #(
    .CNT_W     (8)
  ) u_run_counter (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .clr_i     (cnt_clr),
    .inc_i     (cnt_inc),
    .target_i  (target),
    .count_o   (lock_count_o),
    .reached_o (reached)
  );

  always_comb begin
    nxt_lock = lock_ff;
    if (cfg_ff.lock_dis) begin
      nxt_lock = 1'b0;
    end else if (reached) begin
      nxt_lock = 1'b1;
    end else if (cmp_strobe_i && beyond_thr) begin
      nxt_lock = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_ff <= 1'b0;
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  assign digital_lock_flag_o = lock_ff;

endmodule : lkd_digital_lock_detect

/* tb/lkd_properties.sv */
// Checker: port properties of the lock detector
`timescale 1ns/10ps
module lkd_properties #(
  parameter int DIFF_W = 8
) (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rst_i,
  // Observed ports
  input wire logic              reg_wr_i,
  input wire logic [9:0]        reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              cmp_strobe_i,
  input wire logic [DIFF_W-1:0] cmp_diff_i,
  input wire logic              digital_lock_flag_o,
  input wire logic [7:0]        lock_count_o,
  input wire logic              ref_dc_offset_en_o
);
  logic [7:0] cfg_ff, nxt_cfg, tgt, win, loss;
  logic       in_win, beyond;
  // Mirror of the config register, windows in 100 ps steps
  always_comb begin
    nxt_cfg = (reg_wr_i && reg_addr_i == lkd_pkg::LKD_CFG_ADDR) ? reg_wdata_i : cfg_ff;
    case (cfg_ff[6:5])
      2'h0:    tgt = 8'h05;
      2'h1:    tgt = 8'h10;
      2'h2:    tgt = 8'h40;
      default: tgt = 8'hFF;
    endcase
    win    = cfg_ff[4] ? 8'h0F : 8'h23;
    loss   = cfg_ff[4] ? 8'h1E : 8'h46;
    in_win = cmp_diff_i < win;
    beyond = cmp_diff_i > loss;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cfg_ff <= lkd_pkg::LKD_CFG_RESET;
    else cfg_ff <= nxt_cfg;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_dc_offset_mirror: assert property (ref_dc_offset_en_o == cfg_ff[7])
    else $error("dc offset bit");
  a_flag_at_target: assert property ($rose(digital_lock_flag_o) |-> lock_count_o == tgt)
    else $error("flag rose off target");
  a_set_at_target: assert property (cmp_strobe_i && in_win && !cfg_ff[3] && !reg_wr_i
    && lock_count_o == tgt - 8'h01 |=> digital_lock_flag_o) else $error("flag not set");
  a_in_win_counts: assert property (cmp_strobe_i && in_win && !cfg_ff[3] && !reg_wr_i
    && lock_count_o < tgt |=> lock_count_o == $past(lock_count_o) + 8'h01)
    else $error("run not counted");
  a_out_clears_run: assert property (cmp_strobe_i && !in_win |=> lock_count_o == 8'h00)
    else $error("run not cleared");
  a_beyond_drops_flag: assert property (cmp_strobe_i && beyond |=> !digital_lock_flag_o)
    else $error("flag not cleared");
  a_flag_holds: assert property (digital_lock_flag_o && !(cmp_strobe_i && beyond)
    && !cfg_ff[3] |=> digital_lock_flag_o) else $error("flag dropped");
  a_disable_quiet: assert property (cfg_ff[3] && $past(cfg_ff[3])
    |-> !digital_lock_flag_o && lock_count_o == 8'h00) else $error("disabled yet active");
endmodule : lkd_properties

bind lkd_digital_lock_detect lkd_properties #(.DIFF_W(DIFF_W)) lkd_properties_inst (
  .clk_i, .rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .cmp_strobe_i, .cmp_diff_i,
  .digital_lock_flag_o, .lock_count_o, .ref_dc_offset_en_o);

/* tb/lkd_digital_lock_detect_test.sv */
// Testbench: register access and lock sequences of the lock detector
`timescale 1ns/10ps
module lkd_digital_lock_detect_test;
  logic       clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, cmp_strobe_i = 1'b0;
  logic [9:0] reg_addr_i = 10'h000;
  logic [7:0] reg_wdata_i = 8'h00, cmp_diff_i = 8'h00, reg_rdata_o, lock_count_o;
  logic       digital_lock_flag_o, ref_dc_offset_en_o;
  logic [7:0] tgt [4] = '{8'h05, 8'h10, 8'h40, 8'hFF};
  int         fails = 0, compares = 0, cycles = 0;
  lkd_digital_lock_detect lkd_digital_lock_detect_inst (.clk_i, .rst_i, .reg_wr_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .cmp_strobe_i, .cmp_diff_i,
    .digital_lock_flag_o, .lock_count_o, .ref_dc_offset_en_o);
  always #2 clk_i = ~clk_i;
  // Whole run is under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  task summarize;
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task st(input logic f, input logic [7:0] c);
    chk("flag", {7'h00, f}, {7'h00, digital_lock_flag_o});
    chk("count", c, lock_count_o);
  endtask : st
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk_i) #1;
    reg_wr_i = 1'b0;
  endtask : wr
  task rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk_i) #1;
    reg_addr_i = a;
    @(posedge clk_i) #1;
    chk("rdata", e, reg_rdata_o);
  endtask : rd
  // Strobes every cycle; idle cycles before do not break a run
  task stb(input logic [7:0] d, input int n);
    @(posedge clk_i) #1;
    cmp_strobe_i = 1'b1;
    cmp_diff_i = d;
    repeat (n) @(posedge clk_i);
    #1 cmp_strobe_i = 1'b0;
  endtask : stb
  initial begin
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    rd(10'h018, 8'h06);
    st(1'b0, 8'h00);
    chk("dc", 8'h00, {7'h00, ref_dc_offset_en_o});
    for (int s = 0; s < 4; s++) begin
      wr(10'h018, {1'b0, s[1:0], 5'h06});
      stb(8'h22, tgt[s] - 1);
      st(1'b0, tgt[s] - 8'h01);
      stb(8'h23, 1);
      st(1'b0, 8'h00);
      stb(8'h22, tgt[s] - 1);
      st(1'b0, tgt[s] - 8'h01);
      stb(8'h0A, 1);
      st(1'b1, tgt[s]);
      stb(8'h46, 1);
      st(1'b1, 8'h00);
      stb(8'h47, 1);
      st(1'b0, 8'h00);
    end
    wr(10'h018, 8'h16);
    stb(8'h0E, 5);
    st(1'b1, 8'h05);
    stb(8'h0F, 1);
    st(1'b1, 8'h00);
    stb(8'h1E, 1);
    st(1'b1, 8'h00);
    stb(8'h1F, 1);
    st(1'b0, 8'h00);
    wr(10'h018, 8'h06);
    stb(8'h00, 5);
    st(1'b1, 8'h05);
    wr(10'h018, 8'h0E);
    stb(8'h00, 3);
    st(1'b0, 8'h00);
    wr(10'h018, 8'h86);
    chk("dc", 8'h01, {7'h00, ref_dc_offset_en_o});
    wr(10'h019, 8'h00);
    rd(10'h019, 8'h00);
    rd(10'h018, 8'h86);
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    rd(10'h018, 8'h06);
    summarize();
  end
endmodule : lkd_digital_lock_detect_test
